// ### core/meter_flags_pkg.sv
// constants for the metering event status flag bank
package meter_flags_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ENERGY_STATUS_ADDR = 16'h0400;
    localparam logic [15:0] ZC_STATUS_ADDR     = 16'h0401;
    localparam logic [15:0] ACC_CONFIG_ADDR    = 16'h0410;
    localparam logic [15:0] IRQ_STATUS_ADDR    = 16'h0411;
    localparam logic [15:0] IRQ_MASK_ADDR      = 16'h0412;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ENERGY_READY_BIT   = 0;
    localparam int POWER_SIGN_LSB     = 1;
    localparam int PULSE_FLIP_LSB     = 4;
    localparam int PULSE_ISSUED_LSB   = 6;
    localparam int ENERGY_FLAG_WIDTH  = 8;
    localparam int ZC_FLAG_LSB        = 16;
    localparam int ZC_FLAG_WIDTH      = 16;
    localparam int TIMEOUT_FLAG_WIDTH = 3;
    localparam int INTERVAL_WIDTH     = 13;
    localparam int TIMEBASE_BIT       = 16;
    localparam int IRQ_WIDTH          = 6;

    // irq status groups
    localparam int IRQ_ENERGY_READY = 0;
    localparam int IRQ_POWER_SIGN   = 1;
    localparam int IRQ_PULSE_FLIP   = 2;
    localparam int IRQ_PULSE_ISSUED = 3;
    localparam int IRQ_ZERO_CROSS   = 4;
    localparam int IRQ_TIMEOUT      = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ENERGY_STATUS_RST = 8'h00;
    localparam logic [15:0] ZC_STATUS_RST     = 16'h0000;
    localparam logic [12:0] INTERVAL_RST      = 13'h0000;
    localparam logic        TIMEBASE_RST      = 1'b0;
    localparam logic [5:0]  IRQ_MASK_RST      = 6'h00;
    localparam logic [31:0] READ_ZERO         = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 4;
    localparam int MS_PERIOD_NS    = 1000000;
    localparam int MS_CYCLES       = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MS_COUNT_WIDTH  = 18;

endpackage

// ### core/metering_event_status_flags.sv
// sticky metering event flags with host clear-by-one access
//
// Summary of operation
// RQ1 - A pulse one fall whose energy sign differs from the last sets bit 4.
// RQ2 - Pulse output two follows the same sign test and sets bit 5.
// RQ3 - A change of active power sign on phase A, B or C sets bit 1, 2 or 3.
// RQ4 - Power signs are compared only at an update, every setting plus one ticks.
// RQ5 - Each accumulator update sets the energy ready flag at bit 0.
// RQ6 - Zero crossings on auxiliary channels 5 to 0 set bits 31 to 26.
// RQ7 - Current zero crossings of phases C, B and A set bits 25, 24 and 23.
// RQ8 - A zero crossing of the combined voltage signal sets bit 22.
// RQ9 - Voltage zero crossings of phases C, B and A set bits 21, 20 and 19.
// RQ10 - A missing phase C voltage zero crossing sets bit 18.
// RQ11 - Missing phase B and A voltage zero crossings set bits 17 and 16.
// RQ12 - Each high to low transition of pulse output one sets bit 6.
// RQ13 - Flags reset to zero, clear on a written one (irq status on a read); a same-cycle set wins.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module metering_event_status_flags
    import meter_flags_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wr_data,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    output logic      [31:0] reg_rd_data,
    // pulse outputs and the sign of the energy each pulse carries
    input  wire logic        pulse_output_one,
    input  wire logic        pulse_output_two,
    input  wire logic        pulse1_energy_negative,
    input  wire logic        pulse2_energy_negative,
    // accumulation timing and per-phase power sign, index 0 is phase A
    input  wire logic        half_line_tick,
    input  wire logic [2:0]  phase_power_negative,
    output logic             accumulation_update,
    // zero-crossing and timeout detector pulses, index 0 is phase A
    input  wire logic [5:0]  aux_zero_cross,
    input  wire logic [2:0]  current_zero_cross,
    input  wire logic        combined_zero_cross,
    input  wire logic [2:0]  voltage_zero_cross,
    input  wire logic [2:0]  voltage_cross_timeout,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // sticky update: hardware set beats software clear
    function automatic logic [15:0] sticky(
        input logic [15:0] cur,
        input logic [15:0] evt,
        input logic [15:0] clr
    );
        sticky = (cur & ~clr) | evt;
    endfunction

    function automatic logic hit(input logic [15:0] addr);
        hit = (reg_addr == addr);
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]                energy_status_ff;
    logic [15:0]               zc_status_ff;
    logic [1:0]                pulse_level_ff;
    logic [1:0]                pulse_sign_ff;
    logic [1:0]                pulse_seen_ff;
    logic [2:0]                phase_sign_ff;
    logic                      power_seen_ff;
    logic [MS_COUNT_WIDTH-1:0] ms_cnt_ff;
    logic [INTERVAL_WIDTH-1:0] interval_cnt_ff;
    logic [INTERVAL_WIDTH-1:0] interval_ff;
    logic                      timebase_ff;
    logic                      acc_update_ff;
    logic [IRQ_WIDTH-1:0]      irq_status_ff;
    logic [IRQ_WIDTH-1:0]      irq_mask_ff;
    logic [31:0]               rd_data_ff;
    logic                      irq_ff;

    logic [1:0]                pulse_now;
    logic [1:0]                pulse_sign_now;
    logic [1:0]                pulse_fall;
    logic [1:0]                pulse_flip;
    logic [2:0]                power_flip;
    logic                      ms_tick;
    logic                      interval_tick;
    logic                      nxt_update;
    logic [7:0]                energy_evt;
    logic [15:0]               zc_evt;
    logic [7:0]                energy_clr;
    logic [15:0]               zc_clr;
    logic [IRQ_WIDTH-1:0]      irq_evt;
    logic [IRQ_WIDTH-1:0]      irq_clr;

    // ------------------------------------------------------------
    // pulse output edges and polarity
    // ------------------------------------------------------------
    assign pulse_now      = {pulse_output_two, pulse_output_one};
    assign pulse_sign_now = {pulse2_energy_negative,
                             pulse1_energy_negative};
    assign pulse_fall     = pulse_level_ff & ~pulse_now;

    // the first pulse after reset has no predecessor, so it never flags
    assign pulse_flip = pulse_fall & pulse_seen_ff
                      & (pulse_sign_ff ^ pulse_sign_now); // see RQ1 RQ2

    // reset level is low, so a pin that idles high gives no false fall
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pulse_level_ff <= 2'b00;
        end else begin
            pulse_level_ff <= pulse_now;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pulse_sign_ff <= 2'b00;
            pulse_seen_ff <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pulse_fall[i]) begin
                    pulse_sign_ff[i] <= pulse_sign_now[i]; // see RQ1 RQ2
                    pulse_seen_ff[i] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // accumulation interval timer
    // ------------------------------------------------------------
    // the millisecond prescaler runs free so that a switch of time
    // base does not need a restart
    assign ms_tick = (ms_cnt_ff ==
                      MS_COUNT_WIDTH'(MS_TICK_CYCLES - 1));

    assign interval_tick = timebase_ff ? half_line_tick : ms_tick;

    // greater-or-equal so a setting lowered mid-interval ends it at the next tick
    assign nxt_update = interval_tick
                      && (interval_cnt_ff >= interval_ff); // see RQ4

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ms_cnt_ff <= '0;
        end else if (ms_tick) begin
            ms_cnt_ff <= '0;
        end else begin
            ms_cnt_ff <= ms_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            interval_cnt_ff <= '0;
        end else if (nxt_update) begin
            interval_cnt_ff <= '0; // see RQ4
        end else if (interval_tick) begin
            interval_cnt_ff <= interval_cnt_ff + 1'b1;
        end
    end

    // registered so the update strobe leaves the block from a flop
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_update_ff <= 1'b0;
        end else begin
            acc_update_ff <= nxt_update;
        end
    end

    // ------------------------------------------------------------
    // per-phase power sign
    // ------------------------------------------------------------
    // signs are only looked at while the update pulse stands
    assign power_flip = {3{acc_update_ff & power_seen_ff}}
                      & (phase_sign_ff ^ phase_power_negative); // see RQ3 RQ4

    // first update after reset has no earlier sign and only stores
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_sign_ff <= 3'b000;
            power_seen_ff <= 1'b0;
        end else if (acc_update_ff) begin
            phase_sign_ff <= phase_power_negative; // see RQ4
            power_seen_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // status words
    // ------------------------------------------------------------
    always_comb begin
        energy_evt = 8'h00;
        energy_evt[ENERGY_READY_BIT] = acc_update_ff; // see RQ5
        energy_evt[POWER_SIGN_LSB +: 3] = power_flip; // see RQ3
        energy_evt[PULSE_FLIP_LSB +: 2] = pulse_flip; // see RQ1 RQ2
        energy_evt[PULSE_ISSUED_LSB +: 2] = pulse_fall; // see RQ12
    end

    assign zc_evt = {aux_zero_cross,        // see RQ6
                     current_zero_cross,    // see RQ7
                     combined_zero_cross,   // see RQ8
                     voltage_zero_cross,    // see RQ9
                     voltage_cross_timeout}; // see RQ10 RQ11

    // a clear reaches only the word whose address is written
    assign energy_clr = (reg_wr_en && hit(ENERGY_STATUS_ADDR))
                      ? reg_wr_data[ENERGY_FLAG_WIDTH-1:0] : 8'h00;
    assign zc_clr     = (reg_wr_en && hit(ZC_STATUS_ADDR))
                      ? reg_wr_data[ZC_FLAG_LSB +: ZC_FLAG_WIDTH]
                      : 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            energy_status_ff <= ENERGY_STATUS_RST; // see RQ13
        end else begin
            energy_status_ff <= 8'(sticky({8'h00, energy_status_ff},
                                          {8'h00, energy_evt},
                                          {8'h00, energy_clr})); // see RQ13
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            zc_status_ff <= ZC_STATUS_RST; // see RQ13
        end else begin
            zc_status_ff <= sticky(zc_status_ff, zc_evt, zc_clr); // see RQ13
        end
    end

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    // interval and time base share one word; a new setting takes
    // hold at the next tick without restarting the prescaler
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            interval_ff <= INTERVAL_RST;
            timebase_ff <= TIMEBASE_RST;
        end else if (reg_wr_en && hit(ACC_CONFIG_ADDR)) begin
            interval_ff <= reg_wr_data[INTERVAL_WIDTH-1:0];
            timebase_ff <= reg_wr_data[TIMEBASE_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_mask_ff <= IRQ_MASK_RST;
        end else if (reg_wr_en && hit(IRQ_MASK_ADDR)) begin
            irq_mask_ff <= reg_wr_data[IRQ_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // grouped so one status read names the kind of event; the
    // status words still hold the exact cause
    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_ENERGY_READY] = acc_update_ff;
        irq_evt[IRQ_POWER_SIGN]   = |power_flip;
        irq_evt[IRQ_PULSE_FLIP]   = |pulse_flip;
        irq_evt[IRQ_PULSE_ISSUED] = |pulse_fall;
        irq_evt[IRQ_ZERO_CROSS]   =
            |zc_evt[ZC_FLAG_WIDTH-1:TIMEOUT_FLAG_WIDTH];
        irq_evt[IRQ_TIMEOUT]      = |zc_evt[TIMEOUT_FLAG_WIDTH-1:0];
    end

    // a read hands the whole word over, so the read clears all of it
    assign irq_clr = (reg_rd_en && hit(IRQ_STATUS_ADDR))
                   ? '1 : '0;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_status_ff <= '0;
        end else begin
            irq_status_ff <= IRQ_WIDTH'(sticky(16'(irq_status_ff),
                                               16'(irq_evt),
                                               16'(irq_clr)));
        end
    end

    // one cycle behind the status bit, traded for a clean flop output
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // idle and unmapped reads give zero, so stale data never lingers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data_ff <= READ_ZERO;
        end else if (reg_rd_en) begin
            rd_data_ff <= READ_ZERO;
            unique case (reg_addr)
                ENERGY_STATUS_ADDR:
                    rd_data_ff[ENERGY_FLAG_WIDTH-1:0] <= energy_status_ff;
                ZC_STATUS_ADDR:
                    rd_data_ff[ZC_FLAG_LSB +: ZC_FLAG_WIDTH] <= zc_status_ff;
                ACC_CONFIG_ADDR: begin
                    rd_data_ff[INTERVAL_WIDTH-1:0] <= interval_ff;
                    rd_data_ff[TIMEBASE_BIT]       <= timebase_ff;
                end
                IRQ_STATUS_ADDR:
                    rd_data_ff[IRQ_WIDTH-1:0] <= irq_status_ff;
                IRQ_MASK_ADDR:
                    rd_data_ff[IRQ_WIDTH-1:0] <= irq_mask_ff;
                default:
                    rd_data_ff <= READ_ZERO;
            endcase
        end else begin
            rd_data_ff <= READ_ZERO;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rd_data         = rd_data_ff;
    assign accumulation_update = acc_update_ff;
    assign irq                 = irq_ff;

endmodule // metering_event_status_flags

`default_nettype wire

// ### tb/flags_checker.sv
// port-level assertions for the metering flag bank
`timescale 1ns/1ps
`default_nettype none
module flags_checker
    import meter_flags_pkg::*;
#(parameter int MS_TICK_CYCLES = MS_CYCLES) (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [31:0] reg_rd_data,
    input wire logic        pulse_output_one,
    input wire logic        pulse1_energy_negative,
    input wire logic        accumulation_update,
    input wire logic [5:0]  aux_zero_cross,
    input wire logic [2:0]  current_zero_cross,
    input wire logic        combined_zero_cross,
    input wire logic [2:0]  voltage_zero_cross,
    input wire logic [2:0]  voltage_cross_timeout,
    input wire logic        irq
);
    wire logic [15:0] zc_in = {aux_zero_cross, current_zero_cross,
        combined_zero_cross, voltage_zero_cross, voltage_cross_timeout};
    logic seen_ff;
    logic sign_ff;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // the first pulse after reset has no previous sign to differ from
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            seen_ff <= 1'b0;
            sign_ff <= 1'b0;
        end else if ($fell(pulse_output_one)) begin
            seen_ff <= 1'b1;
            sign_ff <= pulse1_energy_negative;
        end
    end
    sequence rd_on(logic [15:0] a);
        reg_rd_en && reg_addr == a;
    endsequence
    // a cycle without a write keeps a clear out of the picture
    sequence rd_after(e, logic [15:0] a);
        e ##1 !reg_wr_en ##1 rd_on(a);
    endsequence
    rd_idle_zero_a: assert property (
        !$past(reg_rd_en) |-> reg_rd_data == READ_ZERO) else $error("idle");
    unmapped_zero_a: assert property (
        rd_on(16'h0402) |=> reg_rd_data == READ_ZERO) else $error("unmapped");
    zc_low_zero_a: assert property (
        rd_on(ZC_STATUS_ADDR) |=> reg_rd_data[15:0] == 16'h0000)
        else $error("zero-cross word low bits");
    energy_high_zero_a: assert property (
        rd_on(ENERGY_STATUS_ADDR) |=> reg_rd_data[31:8] == 24'h00_0000)
        else $error("energy word high bits");
    zc_sticky_a: assert property (
        rd_after(|zc_in, ZC_STATUS_ADDR) |=> (reg_rd_data[31:16] &
        $past(zc_in, 3)) == $past(zc_in, 3)) else $error("zero-cross lost");
    flip_flag_a: assert property (
        rd_after($fell(pulse_output_one) && seen_ff && sign_ff !=
        pulse1_energy_negative, ENERGY_STATUS_ADDR) |=> reg_rd_data[4])
        else $error("pulse flip flag missing");
    issued_flag_a: assert property (
        rd_after($fell(pulse_output_one), ENERGY_STATUS_ADDR)
        |=> reg_rd_data[6]) else $error("pulse issued flag missing");
    ready_flag_a: assert property (
        rd_after(accumulation_update, ENERGY_STATUS_ADDR)
        |=> reg_rd_data[0]) else $error("energy ready flag missing");
    update_pulse_a: assert property (
        accumulation_update |=> !accumulation_update) else $error("update");
    cover property (accumulation_update ##1 !accumulation_update);
    cover property ($rose(irq));
    cover property (rd_on(ZC_STATUS_ADDR) ##1 reg_rd_data != READ_ZERO);
endmodule // flags_checker

bind metering_event_status_flags flags_checker #(
    .MS_TICK_CYCLES(MS_TICK_CYCLES)) chk (.*);
`default_nettype wire

// ### tb/metering_host_model.sv
// host-side register master that reads and clears the flags
`timescale 1ns/1ps
`default_nettype none
module metering_host_model (
    input  wire logic        ref_clk,
    input  wire logic [31:0] reg_rd_data,
    output var  logic [15:0] reg_addr    = 16'h0000,
    output var  logic [31:0] reg_wr_data = 32'h0000_0000,
    output var  logic        reg_wr_en   = 1'b0,
    output var  logic        reg_rd_en   = 1'b0
);
    // idle address and data are inverted so stale values cannot pass
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en   <= 1'b0;
        reg_addr    <= ~a;
        reg_wr_data <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        #1 d = reg_rd_data;
    endtask
endmodule // metering_host_model
`default_nettype wire

// ### tb/test_metering_event_status_flags.sv
// self-checking bench for the metering flag bank
`timescale 1ns/1ps
`default_nettype none
module test_metering_event_status_flags
    import meter_flags_pkg::*;
;
    localparam int TICKS = 10;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic [15:0] zc_ev   = 16'h0000;
    logic [1:0]  cf      = 2'b00;
    logic [1:0]  cf_neg  = 2'b00;
    logic [2:0]  pw_neg  = 3'h0;
    logic [2:0]  hl_cnt  = 3'h0;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        upd;
    logic        irq;
    int          n_mismatch = 0;
    int          checks     = 0;
    int          cycles     = 0;

    metering_host_model host (.ref_clk(ref_clk), .reg_rd_data(rd_data),
        .reg_addr(addr), .reg_wr_data(wdata), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en));
    metering_event_status_flags #(.MS_TICK_CYCLES(TICKS)) uut (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(addr),
        .reg_wr_data(wdata), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_rd_data(rd_data), .pulse_output_one(cf[0]),
        .pulse_output_two(cf[1]), .pulse1_energy_negative(cf_neg[0]),
        .pulse2_energy_negative(cf_neg[1]), .half_line_tick(hl_cnt == 3'h4),
        .phase_power_negative(pw_neg), .accumulation_update(upd),
        .aux_zero_cross(zc_ev[15:10]), .current_zero_cross(zc_ev[9:7]),
        .combined_zero_cross(zc_ev[6]), .voltage_zero_cross(zc_ev[5:3]),
        .voltage_cross_timeout(zc_ev[2:0]), .irq(irq));

    always #2 ref_clk = ~ref_clk;
    // half line every 5 cycles, so the two timebases give other periods
    always @(posedge ref_clk) begin
        hl_cnt <= (hl_cnt == 3'h4) ? 3'h0 : hl_cnt + 3'h1;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic fire_zc(input logic [15:0] v);
        @(posedge ref_clk);
        zc_ev <= v;
        @(posedge ref_clk);
        zc_ev <= 16'h0000;
    endtask
    task automatic pulse(input logic [1:0] w, input logic [1:0] n);
        @(posedge ref_clk);
        cf     <= w;
        cf_neg <= n;
        @(posedge ref_clk);
        cf <= 2'b00;
        @(posedge ref_clk);
    endtask
    task automatic wait_update(output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (upd !== 1'b1 && n < 200);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(negedge ref_clk);
        check(32'(irq), 32'(e));
    endtask

    task automatic s_regs();
        logic [15:0] a [5];
        logic [31:0] d;
        a = '{ENERGY_STATUS_ADDR, ZC_STATUS_ADDR, ACC_CONFIG_ADDR,
              IRQ_MASK_ADDR, 16'h0402};
        foreach (a[i]) begin
            host.rd(a[i], d);
            check(d, READ_ZERO);
        end
        check(32'(irq), READ_ZERO);
    endtask
    task automatic s_zc();
        logic [15:0] acc;
        logic [31:0] d;
        acc = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            fire_zc(16'h0001 << i);
            acc |= 16'h0001 << i;
            host.rd(ZC_STATUS_ADDR, d);
            check(d, {acc, 16'h0000});
        end
        host.wr(ZC_STATUS_ADDR, READ_ZERO);
        host.rd(ZC_STATUS_ADDR, d);
        check(d, 32'hFFFF_0000);
        host.wr(ZC_STATUS_ADDR, 32'hAAAA_FFFF);
        host.rd(ZC_STATUS_ADDR, d);
        check(d, 32'h5555_0000);
        fork
            fire_zc(16'h8000);
            host.wr(ZC_STATUS_ADDR, 32'hFFFF_0000);
        join
        host.rd(ZC_STATUS_ADDR, d);
        check(d, 32'h8000_0000);
    endtask
    task automatic s_pulse();
        logic [1:0]  w [4];
        logic [1:0]  n [4];
        logic [31:0] e [4];
        logic [31:0] d;
        w = '{2'b11, 2'b11, 2'b11, 2'b01};
        n = '{2'b00, 2'b01, 2'b11, 2'b00};
        e = '{32'h0000_00C0, 32'h0000_00D0, 32'h0000_00E0, 32'h0000_0050};
        foreach (w[i]) begin
            pulse(w[i], n[i]);
            host.rd(ENERGY_STATUS_ADDR, d);
            check(d & 32'h0000_00F0, e[i]);
            host.wr(ENERGY_STATUS_ADDR, 32'h0000_00FF);
        end
    endtask
    task automatic period(input logic [31:0] cfg, input int exp);
        int n;
        host.wr(ACC_CONFIG_ADDR, cfg);
        wait_update(n);
        wait_update(n);
        check(n, exp);
    endtask
    task automatic sign_step(input logic [2:0] s, input logic [31:0] e);
        int n;
        logic [31:0] d;
        wait_update(n);
        host.wr(ENERGY_STATUS_ADDR, 32'h0000_00FF);
        pw_neg <= s;
        wait_update(n);
        // one idle cycle puts the read two cycles after the update
        @(posedge ref_clk);
        host.rd(ENERGY_STATUS_ADDR, d);
        check(d & 32'h0000_000F, e);
    endtask
    task automatic s_irq();
        logic [31:0] d;
        host.wr(IRQ_MASK_ADDR, 32'h0000_0010);
        host.rd(IRQ_MASK_ADDR, d);
        check(d, 32'h0000_0010);
        host.rd(IRQ_STATUS_ADDR, d);
        irq_is(1'b0);
        fire_zc(16'h0200);
        irq_is(1'b1);
        host.rd(IRQ_STATUS_ADDR, d);
        check(d & 32'h0000_0010, 32'h0000_0010);
        irq_is(1'b0);
        host.wr(IRQ_MASK_ADDR, READ_ZERO);
        fire_zc(16'h0200);
        irq_is(1'b0);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        s_regs();
        s_zc();
        s_pulse();
        period(32'h0000_0002, 3 * TICKS);
        period(32'h0001_0001, 10);
        period(READ_ZERO, TICKS);
        sign_step(3'b101, 32'h0000_000B);
        sign_step(3'b100, 32'h0000_0003);
        s_irq();
        final_report();
    end
endmodule // test_metering_event_status_flags
`default_nettype wire
